// [hpp_defs.svh]
`ifndef HPP_DEFS_SVH
`define HPP_DEFS_SVH

// ----------------------------------------------------------------------
// Core-side word addresses in X data space
// ----------------------------------------------------------------------
`define HPP_A_RX_WORD    24'hffffc0
`define HPP_A_TX_WORD    24'hffffc1
`define HPP_A_CONTROL    24'hffffc2
`define HPP_A_STATUS     24'hffffc3
`define HPP_A_PORT_CTL   24'hffffc4
`define HPP_A_GPIO_DIR   24'hffffc5
`define HPP_A_GPIO_DATA  24'hffffc6
`define HPP_A_BASE_ADDR  24'hffffc7

// ----------------------------------------------------------------------
// Core control and status fields
// ----------------------------------------------------------------------
`define HPP_CTL_RX_IE    0
`define HPP_CTL_TX_IE    1
`define HPP_CTL_CMD_IE   2
`define HPP_CTL_MASK     16'h0007
`define HPP_ST_RX_FULL   0
`define HPP_ST_TX_EMPTY  1
`define HPP_ST_CMD_PEND  2

// ----------------------------------------------------------------------
// Port control fields
// ----------------------------------------------------------------------
`define HPP_PC_ENABLE    0
`define HPP_PC_MUX       1
`define HPP_PC_DUAL      2
`define HPP_PC_NOVEC     3
`define HPP_PC_GP_HA8    4
`define HPP_PC_GP_HA9    5
`define HPP_PC_GP_CS     6
`define HPP_PC_GP_REQ    7
`define HPP_PC_GP_ACK    8
`define HPP_PC_MASK      16'h01ff

// ----------------------------------------------------------------------
// Host byte addresses and fields
// ----------------------------------------------------------------------
`define HPP_H_ICR        3'h0
`define HPP_H_CVR        3'h1
`define HPP_H_ISR        3'h2
`define HPP_H_IVR        3'h3
`define HPP_H_HIGH       3'h5
`define HPP_H_MID        3'h6
`define HPP_H_LOW        3'h7
`define HPP_ICR_RREQ     0
`define HPP_ICR_TREQ     1
`define HPP_ICR_INIT     7
`define HPP_CVR_CMD      7
`define HPP_IVR_RESET    8'h0f

// ----------------------------------------------------------------------
// Pin positions
// ----------------------------------------------------------------------
`define HPP_P_AS         8
`define HPP_P_HA8        9
`define HPP_P_HA9        10
`define HPP_P_RW         11
`define HPP_P_DS         12
`define HPP_P_CS         13
`define HPP_P_REQ        14
`define HPP_P_ACK        15
`define HPP_CLR_DELAY    2

`endif

// [hpp_pkg.sv]
package hpp_pkg;

    // Core load/store request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [23:0] addr;
        logic [23:0] wdata;
    } hpp_core_req_t;

    // Interrupt requests toward the core, one-hot by priority
    typedef struct packed {
        logic       cmd;
        logic       tx;
        logic       rx;
        logic [6:0] vector;
    } hpp_irq_t;

    // Host bus access phase
    typedef enum logic [1:0] {
        HP_IDLE,
        HP_READ,
        HP_WRITE
    } hpp_phase_t;

endpackage

// [hpp_core.sv]
// Operation
// - Host bytes move to core word, both flags set
// - Core word read-only; read clears full flag
// - Core transmit write clears transmit-empty flag
// - Core word moves to host bytes, flags set
// - Receive interrupt when full and enabled
// - Transmit interrupt when empty and enabled
// - Command interrupt when pending and enabled; vector supplied
// - Priority: command, then transmit, then receive
// - Full and empty offered as DMA requests
// - Any reset disables port, pins become GPIO
// - Control registers sixteen bits, base address eight, top zero
// - Eight memory-mapped core words
// - Host sees eight byte locations
// - GPIO ownership of pins by enable state
// - Separate or multiplexed address/data host bus
// - Single-strobe or dual-strobe host bus
// - Request pins: vectored or split requests
// - Status changes two cycles after core write
// - Host moves one, two or three bytes
// - Host commands raise core interrupts when enabled
// - Reserved control bits read as zero
// - Pending flag mirrors host command bit
// - Host init clears full, sets empty
`timescale 1ns/1ps
`default_nettype none
`include "hpp_defs.svh"

module hpp_core
    import hpp_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire logic          sw_reset,
    input  wire hpp_core_req_t core_req,
    output logic [23:0]        core_rdata,
    input  wire logic          core_cmd_ack,
    output hpp_irq_t           core_irq,
    output logic               dma_rx_req,
    output logic               dma_tx_req,
    input  wire logic [15:0]   gpio_pins_in,
    output logic [15:0]        gpio_pins_out,
    output logic [15:0]        gpio_pins_oe
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic        port_rst;
    logic [15:0] ctl_q;
    logic [15:0] pctl_q;
    logic [15:0] gpio_dir_q;
    logic [15:0] gpio_dout_q;
    logic [7:0]  base_q;
    logic [23:0] core_rx_word_q;
    logic [23:0] core_tx_word_q;
    logic        core_rx_full_flag_q;
    logic        core_tx_empty_flag_q;
    logic        host_tx_empty_flag_q;
    logic        host_rx_full_flag_q;
    logic [23:0] host_tx_bytes_q;
    logic [23:0] host_rx_bytes_q;
    logic        host_cmd_request_q;
    logic [6:0]  cmd_vector_q;
    logic [7:0]  ivr_q;
    logic        rreq_en_q;
    logic        treq_en_q;
    logic [`HPP_CLR_DELAY-1:0] rd_clr_q;
    logic [`HPP_CLR_DELAY-1:0] wr_clr_q;
    logic [23:0] core_rdata_q;
    logic [2:0]  mux_addr_q;
    logic        mux_hit_q;
    logic [7:0]  host_rdata_q;
    hpp_phase_t  phase_q;

    // Both resets act alike on the whole port
    assign port_rst = !rst_b || sw_reset;

    // ------------------------------------------------------------------
    // Core bus decode
    // ------------------------------------------------------------------
    logic rd_rx;
    logic wr_tx;
    assign rd_rx = core_req.rd && (core_req.addr == `HPP_A_RX_WORD);
    assign wr_tx = core_req.wr && (core_req.addr == `HPP_A_TX_WORD);

    // Core-written registers; control widths masked to their fields
    always_ff @(posedge clk) begin
        if (port_rst) begin
            ctl_q       <= 16'h0000;
            pctl_q      <= 16'h0000;
            gpio_dir_q  <= 16'h0000;
            gpio_dout_q <= 16'h0000;
            base_q      <= 8'h00;
        end else if (core_req.wr) begin
            if (core_req.addr == `HPP_A_CONTROL) begin
                ctl_q <= core_req.wdata[15:0] & `HPP_CTL_MASK;
            end else if (core_req.addr == `HPP_A_PORT_CTL) begin
                pctl_q <= core_req.wdata[15:0] & `HPP_PC_MASK;
            end else if (core_req.addr == `HPP_A_GPIO_DIR) begin
                gpio_dir_q <= core_req.wdata[15:0];
            end else if (core_req.addr == `HPP_A_GPIO_DATA) begin
                gpio_dout_q <= core_req.wdata[15:0];
            end else if (core_req.addr == `HPP_A_BASE_ADDR) begin
                base_q <= core_req.wdata[7:0];
            end
        end
    end

    // Transmit word is write-only storage
    always_ff @(posedge clk) begin
        if (port_rst) begin
            core_tx_word_q <= 24'h000000;
        end else if (wr_tx) begin
            core_tx_word_q <= core_req.wdata;
        end
    end

    // Flag clears from core accesses take effect two cycles later
    always_ff @(posedge clk) begin
        if (port_rst) begin
            rd_clr_q <= '0;
            wr_clr_q <= '0;
        end else begin
            rd_clr_q <= {rd_clr_q[`HPP_CLR_DELAY-2:0], rd_rx};
            wr_clr_q <= {wr_clr_q[`HPP_CLR_DELAY-2:0], wr_tx};
        end
    end

    // Readback; control words carry zeros above bit 15
    logic [15:0] status_w;
    logic [15:0] gpio_rd_w;
    assign status_w = {13'h0000, host_cmd_request_q, core_tx_empty_flag_q,
                       core_rx_full_flag_q};
    assign gpio_rd_w = (gpio_dir_q & gpio_dout_q) | (~gpio_dir_q & gpio_pins_in);

    always_ff @(posedge clk) begin
        if (port_rst) begin
            core_rdata_q <= 24'h000000;
        end else if (core_req.rd) begin
            if (core_req.addr == `HPP_A_RX_WORD) begin
                core_rdata_q <= core_rx_word_q;
            end else if (core_req.addr == `HPP_A_CONTROL) begin
                core_rdata_q <= {8'h00, ctl_q};
            end else if (core_req.addr == `HPP_A_STATUS) begin
                core_rdata_q <= {8'h00, status_w};
            end else if (core_req.addr == `HPP_A_PORT_CTL) begin
                core_rdata_q <= {8'h00, pctl_q};
            end else if (core_req.addr == `HPP_A_GPIO_DIR) begin
                core_rdata_q <= {8'h00, gpio_dir_q};
            end else if (core_req.addr == `HPP_A_GPIO_DATA) begin
                core_rdata_q <= {8'h00, gpio_rd_w};
            end else if (core_req.addr == `HPP_A_BASE_ADDR) begin
                core_rdata_q <= {16'h0000, base_q};
            end else begin
                core_rdata_q <= 24'h000000;
            end
        end
    end
    assign core_rdata = core_rdata_q;

    // ------------------------------------------------------------------
    // Host pin decode
    // ------------------------------------------------------------------
    logic port_en;
    logic mux_mode;
    logic dual_mode;
    logic novec_mode;
    logic rd_act;
    logic wr_act;
    logic cs_act;
    logic ack_act;
    logic host_sel;
    logic [2:0] host_addr;

    assign port_en    = pctl_q[`HPP_PC_ENABLE];
    assign mux_mode   = pctl_q[`HPP_PC_MUX];
    assign dual_mode  = pctl_q[`HPP_PC_DUAL];
    assign novec_mode = pctl_q[`HPP_PC_NOVEC];

    // Strobes are active low in both strobe styles
    assign rd_act = dual_mode ? !gpio_pins_in[`HPP_P_RW] :
                    (!gpio_pins_in[`HPP_P_DS] && gpio_pins_in[`HPP_P_RW]);
    assign wr_act = dual_mode ? !gpio_pins_in[`HPP_P_DS] :
                    (!gpio_pins_in[`HPP_P_DS] && !gpio_pins_in[`HPP_P_RW]);

    // A chip select given over to GPIO leaves the port always selected on the separate bus; the multiplexed bus still compares the pin with base_q
    assign cs_act  = pctl_q[`HPP_PC_GP_CS] || !gpio_pins_in[`HPP_P_CS];
    assign ack_act = !novec_mode && !pctl_q[`HPP_PC_GP_ACK] && !gpio_pins_in[`HPP_P_ACK];
    assign host_sel  = mux_mode ? mux_hit_q : cs_act;
    assign host_addr = mux_mode ? mux_addr_q : gpio_pins_in[`HPP_P_HA9:`HPP_P_AS];

    // Multiplexed bus: latch address while the address strobe is low
    always_ff @(posedge clk) begin
        if (port_rst) begin
            mux_addr_q <= 3'h0;
            mux_hit_q  <= 1'b0;
        end else if (mux_mode && !gpio_pins_in[`HPP_P_AS]) begin
            mux_addr_q <= gpio_pins_in[2:0];
            mux_hit_q  <= ({gpio_pins_in[`HPP_P_CS], gpio_pins_in[`HPP_P_HA9],
                            gpio_pins_in[`HPP_P_HA8], gpio_pins_in[7:3]} == base_q);
        end
    end

    // Access start pulses, one per strobe
    logic start_rd;
    logic start_wr;
    logic start_ack;
    logic host_req_pend;
    assign host_req_pend = (rreq_en_q && host_rx_full_flag_q)
                           || (treq_en_q && host_tx_empty_flag_q);
    assign start_ack = port_en && (phase_q == HP_IDLE) && ack_act && host_req_pend;
    assign start_rd  = port_en && (phase_q == HP_IDLE) && !start_ack
                       && host_sel && rd_act;
    assign start_wr  = port_en && (phase_q == HP_IDLE) && !start_ack
                       && host_sel && wr_act && !rd_act;

    // Phase machine: one action per strobe, wait for release
    always_ff @(posedge clk) begin
        if (port_rst) begin
            phase_q <= HP_IDLE;
        end else begin
            case (phase_q)
                HP_IDLE: begin
                    if (start_ack || start_rd) begin
                        phase_q <= HP_READ;
                    end else if (start_wr) begin
                        phase_q <= HP_WRITE;
                    end
                end
                HP_READ: begin
                    if (!rd_act && !ack_act) begin
                        phase_q <= HP_IDLE;
                    end
                end
                default: begin
                    if (!wr_act) begin
                        phase_q <= HP_IDLE;
                    end
                end
            endcase
        end
    end

    // Host byte read data
    logic [7:0] isr_w;
    assign isr_w = {6'h00, host_tx_empty_flag_q, host_rx_full_flag_q};

    always_ff @(posedge clk) begin
        if (port_rst) begin
            host_rdata_q <= 8'h00;
        end else if (start_ack) begin
            host_rdata_q <= ivr_q;
        end else if (start_rd) begin
            if (host_addr == `HPP_H_ICR) begin
                host_rdata_q <= {6'h00, treq_en_q, rreq_en_q};
            end else if (host_addr == `HPP_H_CVR) begin
                host_rdata_q <= {host_cmd_request_q, cmd_vector_q};
            end else if (host_addr == `HPP_H_ISR) begin
                host_rdata_q <= isr_w;
            end else if (host_addr == `HPP_H_IVR) begin
                host_rdata_q <= ivr_q;
            end else if (host_addr == `HPP_H_HIGH) begin
                host_rdata_q <= host_rx_bytes_q[23:16];
            end else if (host_addr == `HPP_H_MID) begin
                host_rdata_q <= host_rx_bytes_q[15:8];
            end else if (host_addr == `HPP_H_LOW) begin
                host_rdata_q <= host_rx_bytes_q[7:0];
            end else begin
                host_rdata_q <= 8'h00;
            end
        end
    end

    // Host-written control bytes
    logic host_init;
    assign host_init = start_wr && (host_addr == `HPP_H_ICR)
                       && gpio_pins_in[`HPP_ICR_INIT];

    always_ff @(posedge clk) begin
        if (port_rst) begin
            rreq_en_q    <= 1'b0;
            treq_en_q    <= 1'b0;
            ivr_q        <= `HPP_IVR_RESET;
            cmd_vector_q <= 7'h00;
        end else if (start_wr) begin
            if (host_addr == `HPP_H_ICR) begin
                rreq_en_q <= gpio_pins_in[`HPP_ICR_RREQ];
                treq_en_q <= gpio_pins_in[`HPP_ICR_TREQ];
            end else if (host_addr == `HPP_H_CVR) begin
                cmd_vector_q <= gpio_pins_in[6:0];
            end else if (host_addr == `HPP_H_IVR) begin
                ivr_q <= gpio_pins_in[7:0];
            end
        end
    end

    // Host command bit doubles as the core's pending flag; set wins
    logic cmd_write;
    assign cmd_write = start_wr && (host_addr == `HPP_H_CVR);

    always_ff @(posedge clk) begin
        if (port_rst) begin
            host_cmd_request_q <= 1'b0;
        end else if (cmd_write) begin
            host_cmd_request_q <= gpio_pins_in[`HPP_CVR_CMD];
        end else if (core_cmd_ack) begin
            host_cmd_request_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Host to core path
    // ------------------------------------------------------------------
    logic h2c_move;
    assign h2c_move = !host_tx_empty_flag_q && !core_rx_full_flag_q;

    // All flag updates of a path sit in one process, so a handoff is atomic
    always_ff @(posedge clk) begin
        if (port_rst) begin
            host_tx_bytes_q      <= 24'h000000;
            core_rx_word_q       <= 24'h000000;
            host_tx_empty_flag_q <= 1'b1;
            core_rx_full_flag_q  <= 1'b0;
        end else begin
            if (start_wr && (host_addr == `HPP_H_HIGH)) begin
                host_tx_bytes_q[23:16] <= gpio_pins_in[7:0];
            end
            if (start_wr && (host_addr == `HPP_H_MID)) begin
                host_tx_bytes_q[15:8] <= gpio_pins_in[7:0];
            end
            if (start_wr && (host_addr == `HPP_H_LOW)) begin
                host_tx_bytes_q[7:0] <= gpio_pins_in[7:0];
                host_tx_empty_flag_q <= 1'b0;
            end else if (h2c_move) begin
                host_tx_empty_flag_q <= 1'b1;
            end
            if (h2c_move) begin
                core_rx_word_q      <= host_tx_bytes_q;
                core_rx_full_flag_q <= 1'b1;
            end else if (host_init) begin
                core_rx_full_flag_q <= 1'b0;
            end else if (rd_clr_q[`HPP_CLR_DELAY-1]) begin
                core_rx_full_flag_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Core to host path
    // ------------------------------------------------------------------
    logic c2h_move;
    assign c2h_move = !core_tx_empty_flag_q && !host_rx_full_flag_q;

    always_ff @(posedge clk) begin
        if (port_rst) begin
            host_rx_bytes_q      <= 24'h000000;
            core_tx_empty_flag_q <= 1'b1;
            host_rx_full_flag_q  <= 1'b0;
        end else begin
            if (c2h_move) begin
                host_rx_bytes_q      <= core_tx_word_q;
                core_tx_empty_flag_q <= 1'b1;
            end else if (host_init) begin
                core_tx_empty_flag_q <= 1'b1;
            end else if (wr_clr_q[`HPP_CLR_DELAY-1]) begin
                core_tx_empty_flag_q <= 1'b0;
            end
            if (c2h_move) begin
                host_rx_full_flag_q <= 1'b1;
            end else if (start_rd && (host_addr == `HPP_H_LOW)) begin
                host_rx_full_flag_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Core interrupts and DMA requests
    // ------------------------------------------------------------------
    logic cmd_on;
    logic tx_on;
    logic rx_on;
    assign cmd_on = host_cmd_request_q && ctl_q[`HPP_CTL_CMD_IE];
    assign tx_on  = core_tx_empty_flag_q && ctl_q[`HPP_CTL_TX_IE];
    assign rx_on  = core_rx_full_flag_q && ctl_q[`HPP_CTL_RX_IE];

    // Only the highest active source is presented
    assign core_irq.cmd    = cmd_on;
    assign core_irq.tx     = tx_on && !cmd_on;
    assign core_irq.rx     = rx_on && !cmd_on && !tx_on;
    assign core_irq.vector = cmd_vector_q;
    assign dma_rx_req      = core_rx_full_flag_q;
    assign dma_tx_req      = core_tx_empty_flag_q;

    // ------------------------------------------------------------------
    // Pin ownership and drive
    // ------------------------------------------------------------------
    logic [15:0] own_gpio;
    logic [15:0] port_out;
    logic [15:0] port_oe;
    logic        tx_req_w;
    logic        rx_req_w;

    assign own_gpio = port_en ?
        {pctl_q[`HPP_PC_GP_ACK], pctl_q[`HPP_PC_GP_REQ], pctl_q[`HPP_PC_GP_CS], 2'b00,
         pctl_q[`HPP_PC_GP_HA9], pctl_q[`HPP_PC_GP_HA8], 9'h000} : 16'hffff;

    assign tx_req_w = treq_en_q && host_tx_empty_flag_q;
    assign rx_req_w = rreq_en_q && host_rx_full_flag_q;

    // Requests are active low; split mode turns acknowledge into a request
    assign port_out = {!rx_req_w, novec_mode ? !tx_req_w : !host_req_pend,
                       6'h00, host_rdata_q};
    assign port_oe  = {novec_mode, 1'b1, 6'h00, {8{phase_q == HP_READ}}};

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_pin
            assign gpio_pins_out[gi] = own_gpio[gi] ? gpio_dout_q[gi] : port_out[gi];
            assign gpio_pins_oe[gi]  = own_gpio[gi] ? gpio_dir_q[gi] : port_oe[gi];
        end
    endgenerate

endmodule

`default_nettype wire

// [hpp_chk.sv]
`timescale 1ns/1ps
`default_nettype none
`include "hpp_defs.svh"
module hpp_chk
    import hpp_pkg::*;
(
    input wire logic          clk,
    input wire logic          rst_b,
    input wire logic          sw_reset,
    input wire hpp_core_req_t core_req,
    input wire logic [23:0]   core_rdata,
    input wire hpp_irq_t      core_irq,
    input wire logic          dma_rx_req,
    input wire logic          dma_tx_req,
    input wire logic [15:0]   gpio_pins_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b || sw_reset);
    // ------------------------------------------------------------
    // Port checks
    // ------------------------------------------------------------
    chk_rx_irq_cause: assert property (core_irq.rx |-> dma_rx_req)
        else $error("rx irq without full flag");
    chk_tx_irq_cause: assert property (core_irq.tx |-> dma_tx_req)
        else $error("tx irq without empty flag");
    chk_irq_one_hot: assert property ($onehot0({core_irq.cmd, core_irq.tx, core_irq.rx}))
        else $error("more than one irq presented");
    chk_reset_state: assert property (disable iff (1'b0)
        rst_b && ($rose(rst_b) || $fell(sw_reset))
        |-> gpio_pins_oe == 16'h0 && dma_tx_req && !dma_rx_req)
        else $error("port not idle after reset");
    chk_rx_read_clear: assert property (
        core_req.rd && core_req.addr == `HPP_A_RX_WORD |-> ##3 !dma_rx_req)
        else $error("rx full not cleared by read");
    chk_tx_write_delay: assert property (
        core_req.wr && core_req.addr == `HPP_A_TX_WORD && dma_tx_req
        |=> dma_tx_req [*2] ##1 !dma_tx_req)
        else $error("tx empty timing after write wrong");
    chk_rdata_hold: assert property (!core_req.rd |=> $stable(core_rdata))
        else $error("read data moved without a read");
    chk_ctl_upper_zero: assert property (
        core_req.rd && core_req.addr == `HPP_A_CONTROL |=> core_rdata[23:3] == 21'h0)
        else $error("control upper bits not zero");
endmodule
bind hpp_core hpp_chk u_chk (.clk(clk), .rst_b(rst_b), .sw_reset(sw_reset),
    .core_req(core_req), .core_rdata(core_rdata), .core_irq(core_irq),
    .dma_rx_req(dma_rx_req), .dma_tx_req(dma_tx_req), .gpio_pins_oe(gpio_pins_oe));
`default_nettype wire

// [hpp_host_bfm.sv]
`timescale 1ns/1ps
`default_nettype none
module hpp_host_bfm (
    input  wire logic        clk,
    input  wire logic [15:0] dev_out,
    input  wire logic [15:0] dev_oe,
    output logic [15:0]      pins
);
    logic [15:0] host_q;
    // ------------------------------------------------------------
    // Host processor, separate bus, single strobe
    // ------------------------------------------------------------
    // Wire level: device where it drives, host elsewhere
    assign pins = (dev_oe & dev_out) | (~dev_oe & host_q);
    initial host_q = 16'hb800;
    // Byte write at one of eight locations, strobe held one cycle
    task automatic host_write(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk);
        host_q = {5'b10000, a, d};
        @(negedge clk);
        host_q = {5'b10111, a, ~d};
        @(negedge clk);
    endtask
    // Byte read, sampled while the device still drives
    task automatic host_read(input logic [2:0] a, output logic [7:0] d);
        @(negedge clk);
        host_q = {5'b10001, a, 8'h00};
        repeat (2) @(negedge clk);
        d = pins[7:0];
        host_q = {5'b10111, a, ~d};
        @(negedge clk);
    endtask
endmodule
`default_nettype wire

// [tb_hpp_core.sv]
`timescale 1ns/1ps
`default_nettype none
`include "hpp_defs.svh"
module tb_hpp_core
    import hpp_pkg::*;
;
    logic          clk, rst_b, sw_reset, core_cmd_ack, dma_rx_req, dma_tx_req;
    hpp_core_req_t core_req;
    hpp_irq_t      core_irq;
    logic [23:0]   core_rdata, rd;
    logic [15:0]   pins_in, pins_out, pins_oe;
    logic [7:0]    b0, b1, b2;
    int            err_count, samples_checked, cycles;
    // ------------------------------------------------------------
    // Harness
    // ------------------------------------------------------------
    hpp_core uut (.clk(clk), .rst_b(rst_b), .sw_reset(sw_reset), .core_req(core_req),
        .core_rdata(core_rdata), .core_cmd_ack(core_cmd_ack), .core_irq(core_irq),
        .dma_rx_req(dma_rx_req), .dma_tx_req(dma_tx_req), .gpio_pins_in(pins_in),
        .gpio_pins_out(pins_out), .gpio_pins_oe(pins_oe));
    hpp_host_bfm host (.clk(clk), .dev_out(pins_out), .dev_oe(pins_oe), .pins(pins_in));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic check(input string n, input logic [23:0] s, input logic [23:0] e);
        samples_checked++;
        if (s !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic core_wr(input logic [23:0] a, input logic [23:0] d);
        @(negedge clk);
        core_req = '{1'b0, 1'b1, a, d};
        @(negedge clk);
        core_req = '0;
    endtask
    task automatic core_rd(input logic [23:0] a, output logic [23:0] d);
        @(negedge clk);
        core_req = '{1'b1, 1'b0, a, 24'h0};
        @(negedge clk);
        core_req = '0;
        d = core_rdata;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Cuts a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            conclude();
        end
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        sw_reset = 1'b0;
        core_cmd_ack = 1'b0;
        core_req = '0;
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        core_rd(`HPP_A_STATUS, rd);
        check("status", rd, 24'h2);
        check("pin oe", {8'h0, pins_oe}, 24'h0);
        core_wr(`HPP_A_CONTROL, 24'hfffff8);
        core_rd(`HPP_A_CONTROL, rd);
        check("control", rd, 24'h0);
        core_wr(`HPP_A_PORT_CTL, 24'h1);
        host.host_write(`HPP_H_HIGH, 8'ha5);
        host.host_write(`HPP_H_MID, 8'h5a);
        host.host_write(`HPP_H_LOW, 8'h3c);
        check("rx dma", 24'(dma_rx_req), 24'h1);
        core_wr(`HPP_A_CONTROL, 24'h3);
        check("irq both", 24'({core_irq.cmd, core_irq.tx, core_irq.rx}), 24'h2);
        core_wr(`HPP_A_CONTROL, 24'h1);
        check("irq rx", 24'({core_irq.cmd, core_irq.tx, core_irq.rx}), 24'h1);
        core_rd(`HPP_A_RX_WORD, rd);
        check("rx word", rd, 24'ha55a3c);
        repeat (3) @(negedge clk);
        check("rx full", 24'(dma_rx_req), 24'h0);
        core_wr(`HPP_A_CONTROL, 24'h2);
        check("irq tx", 24'({core_irq.cmd, core_irq.tx, core_irq.rx}), 24'h2);
        core_wr(`HPP_A_TX_WORD, 24'h123456);
        repeat (3) @(negedge clk);
        host.host_read(`HPP_H_HIGH, b0);
        host.host_read(`HPP_H_MID, b1);
        host.host_read(`HPP_H_LOW, b2);
        check("host rx", {b0, b1, b2}, 24'h123456);
        core_wr(`HPP_A_CONTROL, 24'h7);
        host.host_write(`HPP_H_CVR, 8'h95);
        check("irq cmd", 24'(core_irq[9:0]), 24'h000215);
        @(negedge clk);
        core_cmd_ack = 1'b1;
        @(negedge clk);
        core_cmd_ack = 1'b0;
        @(negedge clk);
        check("irq after ack", 24'({core_irq.cmd, core_irq.tx, core_irq.rx}), 24'h2);
        core_wr(`HPP_A_TX_WORD, 24'h0000aa);
        repeat (3) @(negedge clk);
        core_wr(`HPP_A_TX_WORD, 24'h0000bb);
        host.host_write(`HPP_H_LOW, 8'h11);
        check("flags before init", 24'({dma_tx_req, dma_rx_req}), 24'h1);
        host.host_write(`HPP_H_ICR, 8'h80);
        check("flags after init", 24'({dma_tx_req, dma_rx_req}), 24'h2);
        core_wr(`HPP_A_PORT_CTL, 24'h000009);
        host.host_write(`HPP_H_ICR, 8'h03);
        check("split requests", 24'({pins_oe[15], pins_in[15:14]}), 24'h4);
        sw_reset = 1'b1;
        @(negedge clk);
        sw_reset = 1'b0;
        host.host_write(`HPP_H_LOW, 8'h77);
        core_rd(`HPP_A_PORT_CTL, rd);
        check("port ctl", rd, 24'h0);
        check("rx ignored", 24'(dma_rx_req), 24'h0);
        core_wr(`HPP_A_GPIO_DIR, 24'h0000ff);
        core_wr(`HPP_A_GPIO_DATA, 24'h0000a5);
        core_rd(`HPP_A_GPIO_DATA, rd);
        check("gpio read", rd, 24'h00bfa5);
        check("gpio pins", {8'h0, pins_in}, 24'h00bfa5);
        check("gpio oe", {8'h0, pins_oe}, 24'h0000ff);
        conclude();
    end
endmodule
`default_nettype wire
